/* rtl/bhp_port.sv */
// Bidirectional 8-bit double-buffered handshake port with Avalon-MM register slave
`timescale 1ns/1ps
// Overview of operation
// - Data pins driven while output-ack is low, released while it is high.
// - Each accepted rising input strobe captures pins into the two-stage input path.
// - Input strobe flag set while any unread byte sits in the input path.
// - Interlocked input-ready high while space exists, drops on strobe edge.
// - Interlocked mode ignores strobe edges while input-ready is low.
// - Pulsed input-ready lasts at most four cycles, cut short by strobe.
// - Input-ready flag reads zero; input-ready held low when input side disabled.
// - Written byte held in output latch; ack edge advances next buffered byte.
// - Control bit 0 picks ack flag: any latch free, or both empty.
// - Interlocked output-ready high while data ready, drops on ack edge.
// - Interlocked mode ignores ack edges while output-ready is low.
// - Pulsed output-ready lasts at most four cycles, cut short by ack.
// - Output-ready flag reads zero; output-ready low when output side disabled.
// - DMA request follows either input or output service request, never both.
// - Data read returns final input latch; write enters output double buffer.
// - First control bit 3 selects interlocked or pulsed output protocol.
// - Second control bit 3 selects interlocked or pulsed input protocol.
// - First control bit 2 is the output-ready interrupt enable; it has no effect as that flag reads zero.
// - Second control bit 2 is the input-ready interrupt enable; it has no effect as that flag reads zero.
// - First control bit 1 gates output-ack interrupt and DMA request.
// - Second control bit 1 gates input-strobe interrupt and DMA request.
// - General control holds output-side and input-side handshake enables.
// - Direction set only by output-ack level; no direction register used.
module bhp_port #(
    parameter int DATA_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [4:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic [DATA_W-1:0] port_data_i,
    output logic      [DATA_W-1:0] port_data_o,
    output logic      [DATA_W-1:0] port_data_oe_o,
    input  wire logic              output_ack_in_i,
    input  wire logic              input_strobe_in_i,
    output logic                   output_ready_out_o,
    output logic                   input_ready_out_o,
    output logic                   output_irq_o,
    output logic                   input_irq_o,
    output logic                   dma_request_out_o
);
    typedef enum logic [1:0] {
        BHP_IDLE = 2'b00,
        BHP_WAIT = 2'b01,
        BHP_DONE = 2'b10
    } bhp_bus_type;

    logic [7:0]        first_port_control_reg;
    logic [7:0]        second_port_control_reg;
    logic [7:0]        gen_ctrl_reg;
    bhp_bus_type       bus_state_reg;
    logic [DATA_W-1:0] initial_input_latch_reg;
    logic [DATA_W-1:0] final_input_latch_reg;
    logic [1:0]        in_count_reg;
    logic [DATA_W-1:0] initial_output_latch_reg;
    logic [DATA_W-1:0] final_output_latch_reg;
    logic [1:0]        out_count_reg;
    logic [2:0]        ack_sync_reg;
    logic [2:0]        stb_sync_reg;
    logic [2:0]        out_pulse_reg;
    logic [2:0]        in_pulse_reg;
    logic              out_rdy_en_reg;
    logic              in_rdy_en_reg;

    logic ack_edge;
    logic stb_edge;
    logic out_side_en;
    logic in_side_en;
    logic out_pulsed;
    logic in_pulsed;
    logic bus_go;
    logic data_read;
    logic data_write;
    logic out_space;
    logic in_space;
    logic ack_take;
    logic stb_take;
    logic output_ack_flag;
    logic input_strobe_flag;
    logic out_svc;
    logic in_svc;
    logic [7:0] status_word;

    assign out_side_en = gen_ctrl_reg[bhp_pkg::GEN_OUT_EN_BIT];
    assign in_side_en  = gen_ctrl_reg[bhp_pkg::GEN_IN_EN_BIT];
    assign out_pulsed  = first_port_control_reg[bhp_pkg::CTRL_MODE_BIT];
    assign in_pulsed   = second_port_control_reg[bhp_pkg::CTRL_MODE_BIT];

    // Rising edges seen only after two synchroniser stages
    assign ack_edge = ack_sync_reg[1] & ~ack_sync_reg[2];
    assign stb_edge = stb_sync_reg[1] & ~stb_sync_reg[2];

    assign out_space = (out_count_reg != 2'd2);
    assign in_space  = (in_count_reg != 2'd2);

    // Edges only count while the matching ready line is up; in pulsed mode the
    // pulse end does not close the window, so data may follow after the pulse.
    assign ack_take = out_side_en && ack_edge && (out_count_reg != 2'd0)
                      && (out_pulsed || output_ready_out_o);
    assign stb_take = in_side_en && stb_edge && in_space
                      && (in_pulsed || input_ready_out_o);

    assign bus_go     = (bus_state_reg == BHP_WAIT);
    assign data_read  = bus_go && avs_read_i  && (avs_address_i == bhp_pkg::OFS_DATA_W);
    assign data_write = bus_go && avs_write_i && (avs_address_i == bhp_pkg::OFS_DATA_W);

    assign output_ack_flag = first_port_control_reg[bhp_pkg::CTRL_STAT_BIT] ?
                             (out_count_reg == 2'd0) : out_space;
    assign input_strobe_flag = (in_count_reg != 2'd0);

    assign out_svc = output_ack_flag && first_port_control_reg[bhp_pkg::CTRL_SVC_EN_BIT];
    assign in_svc  = input_strobe_flag && second_port_control_reg[bhp_pkg::CTRL_SVC_EN_BIT];

    // Ready flags always read zero
    assign status_word = {4'h0, 1'b0, input_strobe_flag, 1'b0, output_ack_flag};

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // Ack idles high: starting at that level keeps drivers off and avoids a false edge
            ack_sync_reg <= 3'h7;
            stb_sync_reg <= 3'h0;
        end else if (ce_i) begin
            ack_sync_reg <= {ack_sync_reg[1:0], output_ack_in_i};
            stb_sync_reg <= {stb_sync_reg[1:0], input_strobe_in_i};
        end
    end

    // Bus slave: two wait cycles, answer on the third cycle of the request
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state_reg     <= BHP_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if (ce_i) begin
            case (bus_state_reg)
                BHP_IDLE: begin
                    avs_waitrequest_o <= 1'b1;
                    if (avs_read_i || avs_write_i) begin
                        bus_state_reg <= BHP_WAIT;
                    end
                end
                BHP_WAIT: begin
                    avs_waitrequest_o <= 1'b0;
                    bus_state_reg     <= BHP_DONE;
                    case (avs_address_i)
                        5'(bhp_pkg::OFS_CTRL_A):   avs_readdata_o <= {24'h0, first_port_control_reg};
                        5'(bhp_pkg::OFS_CTRL_B):   avs_readdata_o <= {24'h0, second_port_control_reg};
                        5'(bhp_pkg::OFS_GEN_CTRL): avs_readdata_o <= {24'h0, gen_ctrl_reg};
                        5'(bhp_pkg::OFS_STATUS):   avs_readdata_o <= {24'h0, status_word};
                        bhp_pkg::OFS_DATA_W:       avs_readdata_o <= {{(32-DATA_W){1'b0}}, final_input_latch_reg};
                        default:                   avs_readdata_o <= 32'h0000_0000;
                    endcase
                end
                BHP_DONE: begin
                    avs_waitrequest_o <= 1'b1;
                    bus_state_reg     <= BHP_IDLE;
                end
                default: begin
                    avs_waitrequest_o <= 1'b1;
                    bus_state_reg     <= BHP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            first_port_control_reg  <= bhp_pkg::CTRL_RESET;
            second_port_control_reg <= bhp_pkg::CTRL_RESET;
            gen_ctrl_reg            <= bhp_pkg::GEN_RESET;
        end else if (ce_i && bus_go && avs_write_i) begin
            case (avs_address_i)
                5'(bhp_pkg::OFS_CTRL_A):   first_port_control_reg  <= avs_writedata_i[7:0];
                5'(bhp_pkg::OFS_CTRL_B):   second_port_control_reg <= avs_writedata_i[7:0];
                5'(bhp_pkg::OFS_GEN_CTRL): gen_ctrl_reg            <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end

    // Output double buffer: final latch drives pins, initial latch queues behind it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            initial_output_latch_reg <= '0;
            final_output_latch_reg   <= '0;
            out_count_reg            <= 2'd0;
        end else if (ce_i) begin
            case ({ack_take, data_write && out_space})
                2'b01: begin
                    if (out_count_reg == 2'd0) begin
                        final_output_latch_reg <= avs_writedata_i[DATA_W-1:0];
                    end else begin
                        initial_output_latch_reg <= avs_writedata_i[DATA_W-1:0];
                    end
                    out_count_reg <= out_count_reg + 2'd1;
                end
                2'b10: begin
                    if (out_count_reg == 2'd2) begin
                        final_output_latch_reg <= initial_output_latch_reg;
                    end
                    out_count_reg <= out_count_reg - 2'd1;
                end
                2'b11: begin
                    if (out_count_reg == 2'd2) begin
                        final_output_latch_reg   <= initial_output_latch_reg;
                        initial_output_latch_reg <= avs_writedata_i[DATA_W-1:0];
                    end else begin
                        final_output_latch_reg <= avs_writedata_i[DATA_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Input double buffer: final latch is what software reads
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            initial_input_latch_reg <= '0;
            final_input_latch_reg   <= '0;
            in_count_reg            <= 2'd0;
        end else if (ce_i) begin
            case ({stb_take, data_read && (in_count_reg != 2'd0)})
                2'b10: begin
                    if (in_count_reg == 2'd0) begin
                        final_input_latch_reg <= port_data_i;
                    end else begin
                        initial_input_latch_reg <= port_data_i;
                    end
                    in_count_reg <= in_count_reg + 2'd1;
                end
                2'b01: begin
                    if (in_count_reg == 2'd2) begin
                        final_input_latch_reg <= initial_input_latch_reg;
                    end
                    in_count_reg <= in_count_reg - 2'd1;
                end
                2'b11: begin
                    if (in_count_reg == 2'd2) begin
                        final_input_latch_reg   <= initial_input_latch_reg;
                        initial_input_latch_reg <= port_data_i;
                    end else begin
                        final_input_latch_reg <= port_data_i;
                    end
                end
                default: ;
            endcase
        end
    end

    // Ready lines: armed when room or data appears, dropped on a taken edge.
    // Dropping is one synchroniser delay late; a truly asynchronous negate
    // would need the raw pin in the output path.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            output_ready_out_o <= 1'b0;
            out_rdy_en_reg     <= 1'b1;
            out_pulse_reg      <= 3'd0;
        end else if (ce_i) begin
            if (!out_side_en) begin
                output_ready_out_o <= 1'b0;
                out_rdy_en_reg     <= 1'b1;
                out_pulse_reg      <= 3'd0;
            end else if (ack_take) begin
                output_ready_out_o <= 1'b0;
                out_rdy_en_reg     <= 1'b1;
                out_pulse_reg      <= 3'd0;
            end else if (out_count_reg != 2'd0 && out_rdy_en_reg) begin
                output_ready_out_o <= 1'b1;
                out_rdy_en_reg     <= 1'b0;
                out_pulse_reg      <= 3'(bhp_pkg::PULSE_CYCLES - 1);
            end else if (out_pulsed && out_pulse_reg != 3'd0) begin
                out_pulse_reg <= out_pulse_reg - 3'd1;
            end else if (out_pulsed) begin
                output_ready_out_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            input_ready_out_o <= 1'b0;
            in_rdy_en_reg     <= 1'b1;
            in_pulse_reg      <= 3'd0;
        end else if (ce_i) begin
            if (!in_side_en) begin
                input_ready_out_o <= 1'b0;
                in_rdy_en_reg     <= 1'b1;
                in_pulse_reg      <= 3'd0;
            end else if (stb_take) begin
                input_ready_out_o <= 1'b0;
                in_rdy_en_reg     <= 1'b1;
                in_pulse_reg      <= 3'd0;
            end else if (in_space && in_rdy_en_reg) begin
                input_ready_out_o <= 1'b1;
                in_rdy_en_reg     <= 1'b0;
                in_pulse_reg      <= 3'(bhp_pkg::PULSE_CYCLES - 1);
            end else if (in_pulsed && in_pulse_reg != 3'd0) begin
                in_pulse_reg <= in_pulse_reg - 3'd1;
            end else if (in_pulsed || !in_space) begin
                input_ready_out_o <= 1'b0;
            end
        end
    end

    // Pins, interrupts and DMA all registered
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            port_data_o       <= '0;
            port_data_oe_o    <= '0;
            output_irq_o      <= 1'b0;
            input_irq_o       <= 1'b0;
            dma_request_out_o <= 1'b0;
        end else if (ce_i) begin
            port_data_o    <= final_output_latch_reg;
            port_data_oe_o <= {DATA_W{~ack_sync_reg[1]}};
            // Ready-status interrupts never fire since those flags read zero
            output_irq_o <= out_svc
                            | (1'b0 & first_port_control_reg[bhp_pkg::CTRL_IRQ_EN_BIT]);
            input_irq_o  <= in_svc
                            | (1'b0 & second_port_control_reg[bhp_pkg::CTRL_IRQ_EN_BIT]);
            dma_request_out_o <= gen_ctrl_reg[bhp_pkg::GEN_DMA_IN_BIT] ? in_svc : out_svc;
        end
    end
endmodule

/* include/bhp_pkg.sv */
// Package: register map, field positions, reset values and timing for the bidirectional handshake port
package bhp_pkg;
    // Register word offsets (byte addresses)
    localparam logic [3:0] OFS_CTRL_A   = 4'h0;   // first_port_control
    localparam logic [3:0] OFS_CTRL_B   = 4'h4;   // second_port_control
    localparam logic [3:0] OFS_GEN_CTRL = 4'h8;   // general port control (enables, DMA select)
    localparam logic [3:0] OFS_STATUS   = 4'hC;   // port status register
    localparam logic [4:0] OFS_DATA_W   = 5'h10;  // port data register
    // Control register fields
    localparam int CTRL_MODE_BIT   = 3;   // 0 interlocked, 1 pulsed
    localparam int CTRL_IRQ_EN_BIT = 2;
    localparam int CTRL_SVC_EN_BIT = 1;
    localparam int CTRL_STAT_BIT   = 0;
    // General control fields
    localparam int GEN_OUT_EN_BIT  = 4;
    localparam int GEN_IN_EN_BIT   = 5;
    localparam int GEN_DMA_IN_BIT  = 0;   // 1: DMA follows input side
    // Status register fields
    localparam int ST_OUT_ACK_BIT   = 0;
    localparam int ST_OUT_RDY_BIT   = 1;
    localparam int ST_IN_STB_BIT    = 2;
    localparam int ST_IN_RDY_BIT    = 3;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] GEN_RESET  = 8'h00;
    // Timing
    localparam int PULSE_CYCLES = 4;      // ready pulse length in clock cycles
    localparam int WAIT_CYCLES  = 1;      // not used by the port; waitrequest is held two cycles per access
endpackage

/* dv/bhp_port_chk.sv */
// Concurrent checks on the handshake port pins and the register bus
`timescale 1ns/1ps
module bhp_port_chk #(
    parameter int DATA_W = 8
) (
    input wire logic              mclk_i,
    input wire logic              rst_i,
    input wire logic [4:0]        avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic [DATA_W-1:0] port_data_oe_o,
    input wire logic              output_ack_in_i,
    input wire logic              output_ready_out_o,
    input wire logic              input_ready_out_o,
    input wire logic              output_irq_o,
    input wire logic              input_irq_o,
    input wire logic              dma_request_out_o
);
    logic [7:0] ca_reg, cb_reg, gn_reg;
    // Shadow of the control registers, updated at the edge a write is accepted
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {ca_reg, cb_reg, gn_reg} <= 24'h000000;
        end else if (avs_write_i && !avs_waitrequest_o) begin
            case (avs_address_i)
                5'(bhp_pkg::OFS_CTRL_A):   ca_reg <= avs_writedata_i[7:0];
                5'(bhp_pkg::OFS_CTRL_B):   cb_reg <= avs_writedata_i[7:0];
                5'(bhp_pkg::OFS_GEN_CTRL): gn_reg <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_answer;
        avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    wait_latency_a: assert property ($rose(avs_read_i || avs_write_i) |-> s_answer)
        else $error("bus answer not two cycles after request");
    wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    drive_on_a: assert property ((!output_ack_in_i) [*4] |=> port_data_oe_o == {DATA_W{1'b1}})
        else $error("drivers off while ack low");
    drive_off_a: assert property (output_ack_in_i [*4] |=> port_data_oe_o == '0)
        else $error("drivers on while ack high");
    ready_flags_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 5'(bhp_pkg::OFS_STATUS)
        |-> !avs_readdata_o[bhp_pkg::ST_OUT_RDY_BIT] && !avs_readdata_o[bhp_pkg::ST_IN_RDY_BIT])
        else $error("ready status flag reads one");
    out_pulse_a: assert property (ca_reg[bhp_pkg::CTRL_MODE_BIT] && $rose(output_ready_out_o)
        |-> ##[1:4] !output_ready_out_o) else $error("output ready pulse too long");
    in_pulse_a: assert property (cb_reg[bhp_pkg::CTRL_MODE_BIT] && $rose(input_ready_out_o)
        |-> ##[1:4] !input_ready_out_o) else $error("input ready pulse too long");
    out_off_a: assert property (!gn_reg[bhp_pkg::GEN_OUT_EN_BIT] && !$past(gn_reg[bhp_pkg::GEN_OUT_EN_BIT], 2)
        |-> !output_ready_out_o) else $error("output ready while side disabled");
    in_off_a: assert property (!gn_reg[bhp_pkg::GEN_IN_EN_BIT] && !$past(gn_reg[bhp_pkg::GEN_IN_EN_BIT], 2)
        |-> !input_ready_out_o) else $error("input ready while side disabled");
    out_gate_a: assert property (!ca_reg[bhp_pkg::CTRL_SVC_EN_BIT] && !$past(ca_reg[bhp_pkg::CTRL_SVC_EN_BIT], 2)
        |-> !output_irq_o) else $error("output request while service disabled");
    in_gate_a: assert property (!cb_reg[bhp_pkg::CTRL_SVC_EN_BIT] && !$past(cb_reg[bhp_pkg::CTRL_SVC_EN_BIT], 2)
        |-> !input_irq_o) else $error("input request while service disabled");
    dma_select_a: assert property ($stable(gn_reg) && gn_reg == $past(gn_reg, 2)
        |-> dma_request_out_o == (gn_reg[bhp_pkg::GEN_DMA_IN_BIT] ? input_irq_o : output_irq_o))
        else $error("dma request follows wrong side");
endmodule

bind bhp_port bhp_port_chk #(.DATA_W(DATA_W)) bhp_port_chk_i (.*);

/* dv/bhp_periph.sv */
// Peripheral model on the far side of the handshake port
`timescale 1ns/1ps
module bhp_periph (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] port_data_o,
    input  wire logic [7:0] port_data_oe_o,
    input  wire logic       output_ready_out_o,
    input  wire logic       input_ready_out_o,
    input  wire logic       send_i,
    input  wire logic       force_i,
    input  wire logic [7:0] send_byte_i,
    input  wire logic [7:0] dly_i,
    output logic      [7:0] port_data_i,
    output logic            output_ack_in_i,
    output logic            input_strobe_in_i,
    output logic            busy_o,
    output logic            got_o,
    output logic      [7:0] got_byte_o
);
    logic [7:0] drv_reg, last_reg, oc, ic;
    logic       drv_en_reg, rdy_q, ip_q, op_pend, ip_pend, go_out, go_in;
    // Undriven bus shows the inverse of its last level so stale data never matches
    assign port_data_i = (|port_data_oe_o) ? port_data_o : (drv_en_reg ? drv_reg : ~last_reg);
    assign busy_o = ic != 8'h00;
    assign go_out = oc == 8'h00 && op_pend;
    // Forced strobes ignore the ready line, to provoke the refusal case
    assign go_in = ic == 8'h01 && (force_i || input_ready_out_o || ip_pend);
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {oc, rdy_q, op_pend, got_o, got_byte_o, last_reg} <= '0;
            output_ack_in_i <= 1'b1;
        end else begin
            last_reg <= port_data_i;
            rdy_q <= output_ready_out_o;
            got_o <= 1'b0;
            op_pend <= (op_pend || (output_ready_out_o && !rdy_q)) && !go_out;
            if (go_out) begin
                output_ack_in_i <= 1'b0;
                oc <= 8'h01;
            end else if (oc != 8'h00) begin
                oc <= oc + 8'h01;
                if (oc == dly_i) begin
                    got_o <= 1'b1;
                    got_byte_o <= port_data_i;
                    output_ack_in_i <= 1'b1;
                end
                if (oc == dly_i + 8'h06) oc <= 8'h00;
            end
        end
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {ic, input_strobe_in_i, drv_en_reg, ip_q, ip_pend, drv_reg} <= '0;
        end else begin
            ip_q <= input_ready_out_o;
            ip_pend <= (ip_pend || (input_ready_out_o && !ip_q)) && !go_in;
            if (send_i) begin
                drv_reg <= send_byte_i;
                ic <= 8'h01;
            end else if (go_in) begin
                drv_en_reg <= 1'b1;
                ic <= 8'h02;
            end else if (ic > 8'h01) begin
                ic <= ic + 8'h01;
                if (ic == 8'h02) input_strobe_in_i <= 1'b1;
                if (ic == 8'h06) input_strobe_in_i <= 1'b0;
                if (ic == 8'h0A) begin
                    drv_en_reg <= 1'b0;
                    ic <= 8'h00;
                end
            end
        end
    end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the bidirectional handshake port
`timescale 1ns/1ps
module tb_top;
    localparam logic [4:0] CA = 5'(bhp_pkg::OFS_CTRL_A);
    localparam logic [4:0] CB = 5'(bhp_pkg::OFS_CTRL_B);
    localparam logic [4:0] GN = 5'(bhp_pkg::OFS_GEN_CTRL);
    localparam logic [4:0] ST = 5'(bhp_pkg::OFS_STATUS);
    localparam logic [4:0] DT = bhp_pkg::OFS_DATA_W;
    logic        mclk_i, rst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o, got_o;
    logic        output_ack_in_i, input_strobe_in_i, output_ready_out_o, input_ready_out_o;
    logic        output_irq_o, input_irq_o, dma_request_out_o, send_i, force_i;
    logic [4:0]  avs_address_i;
    logic [7:0]  port_data_i, port_data_o, port_data_oe_o, send_byte_i, dly_i, got_byte_o;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [7:0]  rxq[$];
    int          err_count, compares, cyc;
    bhp_port bhp_port_i (.*);
    bhp_periph bhp_periph_i (.*);
    always #12.5 mclk_i = ~mclk_i;
    task end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Ceiling is several times the expected run length
    always @(posedge mclk_i) begin
        cyc++;
        if (got_o === 1'b1) rxq.push_back(got_byte_o);
        if (cyc == 6000) begin
            err_count++;
            end_of_test();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e, input string n);
        bus(1'b0, a, 8'h00);
        chk(n, {24'h000000, e}, q);
    endtask
    task send(input logic [7:0] b, input logic f);
        @(posedge mclk_i);
        send_byte_i <= b;
        force_i <= f;
        send_i <= 1'b1;
        @(posedge mclk_i);
        send_i <= 1'b0;
        @(posedge mclk_i);
        while (busy_o !== 1'b0) @(posedge mclk_i);
    endtask
    task wait_rx(input int n);
        while (rxq.size() < n) @(posedge mclk_i);
    endtask
    initial begin
        {mclk_i, ce_i, rst_i, avs_read_i, avs_write_i, send_i, force_i} = 7'b0110000;
        avs_address_i = 5'h00;
        avs_writedata_i = 32'h00000000;
        send_byte_i = 8'h00;
        dly_i = 8'h0C;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(CA, 8'h00, "ctrl_a");
        rd(CB, 8'h00, "ctrl_b");
        rd(GN, 8'h00, "gen_ctrl");
        rd(ST, 8'h01, "status");
        bus(1'b1, 5'h14, 8'hFF);
        rd(5'h14, 8'h00, "unmapped");
        chk("oe_idle", 32'h0, port_data_oe_o);
        $display("test reset done");
        bus(1'b1, CA, 8'h02);
        bus(1'b1, GN, 8'h10);
        bus(1'b1, DT, 8'hA5);
        bus(1'b1, DT, 8'h3C);
        rd(ST, 8'h00, "status_full");
        chk("out_irq_full", 32'h0, output_irq_o);
        wait_rx(2);
        chk("out_byte0", 32'hA5, rxq[0]);
        chk("out_byte1", 32'h3C, rxq[1]);
        repeat (10) @(posedge mclk_i);
        rd(ST, 8'h01, "status_empty");
        chk("out_irq", 32'h1, output_irq_o);
        bus(1'b1, CA, 8'h03);
        bus(1'b1, DT, 8'h5A);
        rd(ST, 8'h00, "status_one_full");
        wait_rx(3);
        repeat (10) @(posedge mclk_i);
        rd(ST, 8'h01, "status_all_empty");
        chk("out_byte2", 32'h5A, rxq[2]);
        $display("test output interlocked done");
        dly_i <= 8'h06;
        bus(1'b1, CA, 8'h0A);
        bus(1'b1, DT, 8'h96);
        bus(1'b1, DT, 8'h69);
        wait_rx(5);
        chk("pulsed_byte0", 32'h96, rxq[3]);
        chk("pulsed_byte1", 32'h69, rxq[4]);
        $display("test output pulsed done");
        bus(1'b1, CA, 8'h00);
        bus(1'b1, GN, 8'h31);
        bus(1'b1, CB, 8'h02);
        send(8'h11, 1'b0);
        send(8'h22, 1'b0);
        chk("in_ready_full", 32'h0, input_ready_out_o);
        send(8'h33, 1'b1);
        rd(ST, 8'h05, "status_in");
        chk("in_irq", 32'h1, input_irq_o);
        chk("dma_in", 32'h1, dma_request_out_o);
        bus(1'b1, GN, 8'h30);
        repeat (3) @(posedge mclk_i);
        chk("dma_out", 32'h0, dma_request_out_o);
        rd(DT, 8'h11, "in_byte0");
        rd(DT, 8'h22, "in_byte1");
        rd(ST, 8'h01, "status_in_empty");
        $display("test input interlocked done");
        bus(1'b1, CB, 8'h0A);
        send(8'h44, 1'b0);
        send(8'h55, 1'b0);
        rd(DT, 8'h44, "pulsed_in0");
        rd(DT, 8'h55, "pulsed_in1");
        $display("test input pulsed done");
        bus(1'b1, GN, 8'h00);
        repeat (4) @(posedge mclk_i);
        chk("out_ready_off", 32'h0, output_ready_out_o);
        chk("in_ready_off", 32'h0, input_ready_out_o);
        $display("test disable done");
        end_of_test();
    end
endmodule
